// >>> verilog/fbsr_top.sv
module fbsr_top (
  input  wire logic                     clk_sys_in,
  input  wire logic                     rst_in,
  input  wire fbsr_pkg::fbsr_pins_t     pins_in,
  output logic     [fbsr_pkg::STAGES-1:0] q_out,
  output logic                          shift_stall_out,
  output logic                          snap_valid_out,
  output logic [fbsr_pkg::FIFO_WIDTH-1:0] snap_data_out,
  input  wire logic                     snap_ready_in
);

  fbsr_pkg::fbsr_pins_t        s1_q;
  fbsr_pkg::fbsr_pins_t        s2_q;
  fbsr_pkg::fbsr_pins_t        s3_q;
  fbsr_pkg::fbsr_pins_t        pins_q;
  fbsr_pkg::fbsr_pins_t        pins_d;
  logic                        clk_prev_q;
  logic                        pend_q;
  logic                        pend_bit_q;
  logic [fbsr_pkg::STAGES-1:0] stage_q;
  logic [fbsr_pkg::STAGES-1:0] stage_d;
  fbsr_pkg::fbsr_op_t          op;
  logic                        fifo_ready;

  // three-flop sampling; a bit moves once stages two and three agree
  wire [8:0] agree = ~(s2_q ^ s3_q);
  assign pins_d = (s2_q & agree) | (pins_q & ~agree);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s1_q   <= fbsr_pkg::PINS_RST;
      s2_q   <= fbsr_pkg::PINS_RST;
      s3_q   <= fbsr_pkg::PINS_RST;
      pins_q <= fbsr_pkg::PINS_RST;
    end else begin
      s1_q   <= pins_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      pins_q <= pins_d;
    end
  end

  // operation select, clear first
  wire clr_act   = ~pins_q.clear_n;
  wire load_act  = pins_q.clear_n & pins_q.load;
  wire clk_rise  = pins_q.shift_clk & ~clk_prev_q;
  wire shift_req = (clk_rise | pend_q) & ~clr_act & ~load_act;
  wire shift_go  = shift_req & fifo_ready;
  wire shift_bit = clk_rise ? pins_q.serial : pend_bit_q;

  assign op = clr_act  ? fbsr_pkg::FBSR_CLEAR  :
              load_act ? fbsr_pkg::FBSR_PRESET :
              shift_go ? fbsr_pkg::FBSR_SHIFT  : fbsr_pkg::FBSR_HOLD;

  always_comb begin
    case (op)
      fbsr_pkg::FBSR_CLEAR:  stage_d = fbsr_pkg::STAGE_RST;
      fbsr_pkg::FBSR_PRESET: stage_d = stage_q | pins_q.preset;
      fbsr_pkg::FBSR_SHIFT:  stage_d = {stage_q[3:0], shift_bit};
      default:               stage_d = stage_q;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      stage_q    <= fbsr_pkg::STAGE_RST;
      clk_prev_q <= 1'b0;
      pend_q     <= 1'b0;
      pend_bit_q <= 1'b0;
    end else begin
      stage_q    <= stage_d;
      clk_prev_q <= pins_q.shift_clk;
      pend_q     <= shift_req & ~fifo_ready;
      pend_bit_q <= shift_bit;
    end
  end

  // stage A is bit 0, stage E bit 4
  assign q_out           = stage_q;
  assign shift_stall_out = pend_q;

  // every shifted word is also queued for a parallel reader
  fbsr_fifo #(
    .WIDTH (fbsr_pkg::FIFO_WIDTH),
    .DEPTH (fbsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (shift_go),
    .in_data_in    (stage_d),
    .in_ready_out  (fifo_ready),
    .out_valid_out (snap_valid_out),
    .out_data_out  (snap_data_out),
    .out_ready_in  (snap_ready_in)
  );

  default clocking top_cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  clear_zero_a: assert property (clr_act |=> stage_q == 5'h00)
    else $error("clear did not zero stages");
  clear_wins_a: assert property (clr_act && pins_q.load |=> stage_q == 5'h00)
    else $error("preset beat clear");
  preset_or_a: assert property (load_act |=> stage_q == ($past(stage_q) | $past(pins_q.preset)))
    else $error("preset result wrong");
  clear_pin_a: assert property ((!pins_in.clear_n)[*4] |-> ##2 stage_q == 5'h00)
    else $error("clear pin did not reach stages");
  hold_steady_a: assert property (!clk_rise && !pend_q && !clr_act && !load_act
                                  |=> $stable(stage_q))
    else $error("stages moved without edge");
  shift_chain_a: assert property (op == fbsr_pkg::FBSR_SHIFT
                                  |=> stage_q[4:1] == $past(stage_q[3:0]))
    else $error("stage chain broke");
  shift_entry_a: assert property (clk_rise && shift_go
                                  |=> stage_q[0] == $past(pins_q.serial))
    else $error("serial input not in stage A");
  shift_guard_a: assert property (clr_act || load_act |-> !shift_go)
    else $error("shift during clear or preset");
  stall_push_a: assert property (pend_q && !clr_act && !load_act && fifo_ready
                                 |-> op == fbsr_pkg::FBSR_SHIFT ##1 !pend_q)
    else $error("stalled shift not released");

  clear_seen_c: cover property (clr_act ##1 !clr_act);
  preset_seen_c: cover property (load_act && pins_q.preset != 5'h00);
  shift_seen_c: cover property (op == fbsr_pkg::FBSR_SHIFT [*1] ##[1:20] op == fbsr_pkg::FBSR_SHIFT);
  stall_seen_c: cover property (pend_q ##[1:40] !pend_q);

endmodule : fbsr_top

// >>> common/fbsr_pkg.sv
package fbsr_pkg;

  localparam int STAGES     = 5;
  localparam int FIFO_WIDTH = 5;
  localparam int FIFO_DEPTH = 16;

  localparam logic [4:0] STAGE_RST = 5'h00;
  localparam logic [8:0] PINS_RST  = 9'h100;

  // pins from the controlling logic, sampled as one group
  typedef struct packed {
    logic       clear_n;
    logic       load;
    logic [4:0] preset;
    logic       serial;
    logic       shift_clk;
  } fbsr_pins_t;

  typedef enum logic [1:0] {
    FBSR_HOLD   = 2'b00,
    FBSR_CLEAR  = 2'b01,
    FBSR_PRESET = 2'b10,
    FBSR_SHIFT  = 2'b11
  } fbsr_op_t;

endpackage : fbsr_pkg

// >>> verilog/fbsr_fifo.sv
module fbsr_fifo #(
  parameter int WIDTH = fbsr_pkg::FIFO_WIDTH,
  parameter int DEPTH = fbsr_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             out_valid_q;
  logic [WIDTH-1:0] out_data_q;

  wire push     = in_valid_in & in_ready_out;
  wire out_free = ~out_valid_q | out_ready_in;
  wire pop      = out_free & (count_q != '0);

  assign in_ready_out  = count_q != FULL_COUNT;
  assign out_valid_out = out_valid_q;
  assign out_data_out  = out_data_q;
  assign count_d       = count_q + (AW + 1)'(push) - (AW + 1)'(pop);

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q  <= count_d;
      if (pop) begin
        out_data_q <= mem_q[rd_ptr_q];
      end
      if (out_free) begin
        out_valid_q <= pop;
      end
    end
  end

  default clocking fifo_cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  fifo_bound_a: assert property (count_q <= FULL_COUNT)
    else $error("fifo count above depth");
  fifo_hold_a: assert property (out_valid_q && !out_ready_in |=> out_valid_q && $stable(out_data_q))
    else $error("fifo output dropped before taken");

endmodule : fbsr_fifo

// >>> verif/fbsr_ctrl.sv
module fbsr_ctrl (
  input  wire logic            clk_sys_in,
  output fbsr_pkg::fbsr_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins_out = fbsr_pkg::PINS_RST;
  // one pin state, held long enough for the samplers
  task automatic set(input logic c, input logic l, input logic [4:0] p);
    pins_out.clear_n = c;
    pins_out.load    = l;
    pins_out.preset  = p;
    repeat (8) @(negedge clk_sys_in);
  endtask : set
  // clear first, then present data and pulse load
  task automatic load_word(input logic [4:0] d);
    set(1'b0, 1'b0, 5'h00);
    set(1'b1, 1'b0, d);
    set(1'b1, 1'b1, d);
    set(1'b1, 1'b0, 5'h00);
  endtask : load_word
  // full shift clock period with clear high, load and preset low
  task automatic shift_bit(input logic s);
    pins_out.serial    = s;
    pins_out.shift_clk = 1'b1;
    repeat (8) @(negedge clk_sys_in);
    pins_out.shift_clk = 1'b0;
    pins_out.serial    = ~s;
    repeat (8) @(negedge clk_sys_in);
  endtask : shift_bit
endmodule : fbsr_ctrl

// >>> verif/fbsr_top_test.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module fbsr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys_in    = 1'b0;
  logic                 rst_in        = 1'b1;
  logic                 snap_ready_in = 1'b0;
  fbsr_pkg::fbsr_pins_t pins;
  logic [4:0]           q_out;
  logic [4:0]           snap_data_out;
  logic                 shift_stall_out;
  logic                 snap_valid_out;
  logic [4:0]           exp_q         = 5'h00;
  logic [17:0]          pat           = 18'h2C5A9;
  logic [4:0]           words[$];
  int                   err_count     = 0;
  int                   compares      = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  fbsr_ctrl fbsr_ctrl_i (.clk_sys_in(clk_sys_in), .pins_out(pins));
  fbsr_top fbsr_top_i (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .pins_in        (pins),
    .q_out          (q_out),
    .shift_stall_out(shift_stall_out),
    .snap_valid_out (snap_valid_out),
    .snap_data_out  (snap_data_out),
    .snap_ready_in  (snap_ready_in)
  );
  task automatic finish_test;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic t_load_clear;
    fbsr_ctrl_i.load_word(5'h15);
    `CHK(q_out, 5'h15)
    fbsr_ctrl_i.set(1'b0, 1'b0, 5'h00);
    `CHK(q_out, 5'h00)
    $display("t_load_clear done");
  endtask : t_load_clear
  task automatic t_preset;
    fbsr_ctrl_i.load_word(5'h05);
    fbsr_ctrl_i.set(1'b1, 1'b1, 5'h0A);
    `CHK(q_out, 5'h0F)
    fbsr_ctrl_i.set(1'b0, 1'b1, 5'h1F);
    `CHK(q_out, 5'h00)
    fbsr_ctrl_i.set(1'b1, 1'b0, 5'h00);
    $display("t_preset done");
  endtask : t_preset
  task automatic t_shift_fill;
    for (int i = 0; i < 17; i++) begin
      fbsr_ctrl_i.shift_bit(pat[i]);
      exp_q = {exp_q[3:0], pat[i]};
      words.push_back(exp_q);
      `CHK(q_out, exp_q)
    end
    `CHK(shift_stall_out, 1'b0)
    fbsr_ctrl_i.shift_bit(pat[17]);
    `CHK(shift_stall_out, 1'b1)
    `CHK(q_out, exp_q)
    exp_q = {exp_q[3:0], pat[17]};
    words.push_back(exp_q);
    $display("t_shift_fill done");
  endtask : t_shift_fill
  task automatic t_drain;
    logic [4:0] w;
    snap_ready_in = 1'b1;
    // look at the word while it stands, before the edge that takes it
    for (int i = 0; i < 200 && words.size() > 0; i++) begin
      if (snap_valid_out === 1'b1) begin
        w = words.pop_front();
        `CHK(snap_data_out, w)
      end
      @(negedge clk_sys_in);
    end
    @(negedge clk_sys_in);
    snap_ready_in = 1'b0;
    if (words.size() > 0) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, words.size(), 0);
      finish_test();
    end
    repeat (4) @(negedge clk_sys_in);
    `CHK(snap_valid_out, 1'b0)
    `CHK(q_out, exp_q)
    $display("t_drain done");
  endtask : t_drain
  initial begin
    repeat (8) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    t_load_clear();
    t_preset();
    t_shift_fill();
    t_drain();
    finish_test();
  end
endmodule : fbsr_top_test
